// ---- rtl/drs_pkg.sv ----
// Package of constants and types for the dual rail sequencer supervisor
package drs_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
   localparam int unsigned RST_DELAY_MS   = 30;
   localparam int unsigned RST_DELAY_CYC  = (CLK_FREQ_HZ / 1000) * RST_DELAY_MS;
   localparam int unsigned CNT_W          = 22;

   // ------------------------------------------------------------
   // AXI4-Lite register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS     = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;
   localparam logic [7:0] ADDR_CTRL       = 8'h0C;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   // Interrupt event bit positions
   localparam int unsigned EV_W           = 4;
   localparam int unsigned EV_RST_ASSERT  = 0;
   localparam int unsigned EV_RST_RELEASE = 1;
   localparam int unsigned EV_RAIL1_FAIL  = 2;
   localparam int unsigned EV_RAIL2_FAIL  = 3;

   // Reset values
   localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
   localparam logic            SW_HOLD_RST  = 1'b0;

   // Sequencer states
   typedef enum logic [2:0] {
      DRS_OFF,
      DRS_FIRST_UP,
      DRS_BOTH_UP
   } drs_state_t;

   // Comparator flags from one rail monitor
   typedef struct packed {
      logic above_83;
      logic above_95;
   } drs_rail_mon_t;

endpackage

// ---- rtl/drs_delay_timer.sv ----
// Restartable reset release delay counter
module drs_delay_timer
   import drs_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   input  wire logic i_ce,
   input  wire logic i_hold,
   output logic      o_done
);

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   logic [CNT_W-1:0] count;

   // Any hold restarts the count from zero, so a glitchy reset source
   // never shortens the release delay
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count  <= '0;
         o_done <= 1'b0;
      end else if (i_ce) begin
         if (i_hold) begin
            count  <= '0;
            o_done <= 1'b0;
         end else if (count == CNT_W'(RST_DELAY_CYC - 1)) begin
            o_done <= 1'b1;
         end else begin
            count  <= count + CNT_W'(1);
         end
      end
   end

endmodule

// ---- rtl/drs_sequencer.sv ----
// Top level: rail sequencer, power good, supervisor reset and AXI4-Lite registers
//
// Contract
// - Enable input high keeps both rails off; low starts power-up.
// - Order select high: second rail first, first rail waits for the second rail's 83% flag.
// - Second-rail-first order: first rail off when second rail drops below 83%.
// - Order select low: first rail first, second rail after first reaches 83%.
// - First-rail good output released once first rail reaches 95%.
// - First-rail good output driven low when first rail below 95%.
// - Reset output asserted while either manual reset input is low.
// - Reset released 30 ms after second rail above 95%, manual resets idle.
// - Reset driven low at once when second rail falls below 95%.
// - Manual reset inputs pulled up, undriven reads inactive.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
module drs_sequencer
   import drs_pkg::*;
(
   input  wire logic        I_REF_CLK,
   input  wire logic        I_ARST_N,
   input  wire logic        I_CE,
   // Pins
   input  wire logic        I_ENABLE_N,
   input  wire logic        I_ORDER_SELECT,
   input  wire logic        I_MANUAL_RESET_A_N,
   input  wire logic        I_MANUAL_RESET_B_N,
   input  wire logic        I_FIRST_RAIL_83,
   input  wire logic        I_FIRST_RAIL_95,
   input  wire logic        I_SECOND_RAIL_83,
   input  wire logic        I_SECOND_RAIL_95,
   output logic             O_FIRST_RAIL_ON,
   output logic             O_SECOND_RAIL_ON,
   output logic             O_FIRST_RAIL_GOOD_OE,
   output logic             O_SUPERVISOR_RESET_N_OE,
   output logic             O_IRQ,
   // AXI4-Lite slave
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   output logic [1:0]       O_BRESP,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   input  wire logic [7:0]  I_ARADDR,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   output logic             O_RVALID,
   input  wire logic        I_RREADY
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   drs_state_t      state;
   drs_state_t      next_state;
   drs_rail_mon_t   mon1;
   drs_rail_mon_t   mon2;
   logic            mr_a_n;
   logic            mr_b_n;
   logic            sw_hold;
   logic            rst_hold;
   logic            delay_done;
   logic            rst_released;
   logic            rail1_good;
   logic            rail2_good;
   logic            rail1_good_q;
   logic            rail2_good_q;
   logic [EV_W-1:0] irq_stat;
   logic [EV_W-1:0] irq_mask;
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] w1c;
   logic            aw_held;
   logic            w_held;
   logic [7:0]      aw_addr;
   logic [31:0]     w_data;
   logic [3:0]      w_strb;
   logic            wr_go;

   // Pins are synchronous to the clock; pull-ups are modelled by the
   // pad, so a floating manual reset arrives here as a one
   assign mon1   = '{above_83: I_FIRST_RAIL_83, above_95: I_FIRST_RAIL_95};
   assign mon2   = '{above_83: I_SECOND_RAIL_83, above_95: I_SECOND_RAIL_95};
   assign mr_a_n = I_MANUAL_RESET_A_N;
   assign mr_b_n = I_MANUAL_RESET_B_N;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Next state; order select is sampled live so a change takes effect
   always_comb begin
      next_state = state;
      case (state)
         DRS_OFF: begin
            if (!I_ENABLE_N) begin
               next_state = DRS_FIRST_UP;
            end
         end
         DRS_FIRST_UP: begin
            if (I_ENABLE_N) begin
               next_state = DRS_OFF;
            end else if (I_ORDER_SELECT ? mon2.above_83 : mon1.above_83) begin
               next_state = DRS_BOTH_UP;
            end
         end
         DRS_BOTH_UP: begin
            if (I_ENABLE_N) begin
               next_state = DRS_OFF;
            end else if (I_ORDER_SELECT && !mon2.above_83) begin
               next_state = DRS_FIRST_UP;
            end
         end
         default: begin
            next_state = DRS_OFF;
         end
      endcase
   end

   // State register
   // I_CE low holds the sequence, the rails and the delay where they are
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state <= DRS_OFF;
      end else if (I_CE) begin
         state <= next_state;
      end
   end

   // Rail enables decoded from next state so they come from flops
   // Decoding next_state rather than state saves a cycle of rail delay
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_FIRST_RAIL_ON  <= 1'b0;
         O_SECOND_RAIL_ON <= 1'b0;
      end else if (I_CE) begin
         case (next_state)
            DRS_FIRST_UP: begin
               O_FIRST_RAIL_ON  <= !I_ORDER_SELECT;
               O_SECOND_RAIL_ON <= I_ORDER_SELECT;
            end
            DRS_BOTH_UP: begin
               O_FIRST_RAIL_ON  <= 1'b1;
               O_SECOND_RAIL_ON <= 1'b1;
            end
            default: begin
               O_FIRST_RAIL_ON  <= 1'b0;
               O_SECOND_RAIL_ON <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Power good and supervisor reset
   // ------------------------------------------------------------
   // Good flags are qualified by enable so shutdown always drops them
   assign rail1_good = !I_ENABLE_N && mon1.above_95;
   assign rail2_good = !I_ENABLE_N && mon2.above_95;

   // Any reset condition holds the delay timer in restart
   assign rst_hold = I_ENABLE_N || !mon2.above_95 || !mr_a_n || !mr_b_n
                     || sw_hold;

   drs_delay_timer u_delay (
      .i_clk    (I_REF_CLK),
      .i_arst_n (I_ARST_N),
      .i_ce     (I_CE),
      .i_hold   (rst_hold),
      .o_done   (delay_done)
   );

   // Power good: enable high pulls the open-drain pin low
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_FIRST_RAIL_GOOD_OE <= 1'b1;
         rail1_good_q         <= 1'b0;
      end else if (I_CE) begin
         O_FIRST_RAIL_GOOD_OE <= !rail1_good;
         rail1_good_q         <= rail1_good;
      end
   end

   // Supervisor reset: asserts on the edge after any hold cause, so an
   // overload is never hidden behind the release delay
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_SUPERVISOR_RESET_N_OE <= 1'b1;
         rst_released            <= 1'b0;
      end else if (I_CE) begin
         O_SUPERVISOR_RESET_N_OE <= rst_hold || !delay_done;
         rst_released            <= !rst_hold && delay_done;
      end
   end

   // Second rail good history, kept only to spot its loss for the interrupt
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rail2_good_q <= 1'b0;
      end else if (I_CE) begin
         rail2_good_q <= rail2_good;
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   // Events: reset asserted/released, first or second rail lost good
   assign events[EV_RST_ASSERT]  = rst_released && (rst_hold || !delay_done);
   assign events[EV_RST_RELEASE] = !rst_released && !rst_hold && delay_done;
   assign events[EV_RAIL1_FAIL]  = rail1_good_q && !rail1_good;
   assign events[EV_RAIL2_FAIL]  = rail2_good_q && !rail2_good;

   // Sticky status; a new event wins over a write-one clear
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         irq_stat <= '0;
      end else if (I_CE) begin
         irq_stat <= (irq_stat & ~w1c) | events;
      end
   end

   // Level interrupt from a flop
   // Uses the next status value so the line follows a clear without lag
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_IRQ <= 1'b0;
      end else if (I_CE) begin
         O_IRQ <= |(((irq_stat & ~w1c) | events) & irq_mask);
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   // A write completes once both halves are held and no response is
   // pending; the held copies keep the decode stable for that cycle
   assign wr_go = aw_held && w_held && !O_BVALID;
   assign w1c   = (wr_go && aw_addr == ADDR_IRQ_STAT && w_strb[0])
                  ? w_data[EV_W-1:0] : '0;

   // Address and data are taken in either order and held until both
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr   <= '0;
         w_data    <= '0;
         w_strb    <= '0;
         O_AWREADY <= 1'b0;
         O_WREADY  <= 1'b0;
         O_BVALID  <= 1'b0;
         O_BRESP   <= RESP_OKAY;
      end else if (I_CE) begin
         O_AWREADY <= !aw_held && !(O_AWREADY && I_AWVALID);
         O_WREADY  <= !w_held && !(O_WREADY && I_WVALID);
         if (O_AWREADY && I_AWVALID) begin
            aw_held <= 1'b1;
            aw_addr <= I_AWADDR;
         end
         if (O_WREADY && I_WVALID) begin
            w_held <= 1'b1;
            w_data <= I_WDATA;
            w_strb <= I_WSTRB;
         end
         if (wr_go) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            O_BVALID <= 1'b1;
            O_BRESP  <= (aw_addr == ADDR_STATUS || aw_addr == ADDR_IRQ_STAT
                         || aw_addr == ADDR_IRQ_MASK || aw_addr == ADDR_CTRL)
                        ? RESP_OKAY : RESP_SLVERR;
         end else if (O_BVALID && I_BREADY) begin
            O_BVALID <= 1'b0;
         end
      end
   end

   // Interrupt mask: a one lets the matching status bit reach O_IRQ
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         irq_mask <= IRQ_MASK_RST;
      end else if (I_CE && wr_go && w_strb[0] && aw_addr == ADDR_IRQ_MASK) begin
         irq_mask <= w_data[EV_W-1:0];
      end
   end

   // Software hold of the reset output, acting as a third manual reset
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         sw_hold <= SW_HOLD_RST;
      end else if (I_CE && wr_go && w_strb[0] && aw_addr == ADDR_CTRL) begin
         sw_hold <= w_data[0];
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   // Read data is captured at the address edge and held with RVALID, so
   // a stalled RREADY never sees the value move under it
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_ARREADY <= 1'b0;
         O_RVALID  <= 1'b0;
         O_RDATA   <= '0;
         O_RRESP   <= RESP_OKAY;
      end else if (I_CE) begin
         O_ARREADY <= !O_RVALID && !(O_ARREADY && I_ARVALID);
         if (O_ARREADY && I_ARVALID) begin
            O_RVALID <= 1'b1;
            O_RRESP  <= RESP_OKAY;
            case (I_ARADDR)
               ADDR_STATUS: begin
                  O_RDATA <= {24'h000000, state == DRS_BOTH_UP, O_FIRST_RAIL_ON,
                              O_SECOND_RAIL_ON, !O_FIRST_RAIL_GOOD_OE,
                              !O_SUPERVISOR_RESET_N_OE, mr_b_n, mr_a_n,
                              !I_ENABLE_N};
               end
               ADDR_IRQ_STAT: begin
                  O_RDATA <= {28'h0000000, irq_stat};
               end
               ADDR_IRQ_MASK: begin
                  O_RDATA <= {28'h0000000, irq_mask};
               end
               ADDR_CTRL: begin
                  O_RDATA <= {31'h00000000, sw_hold};
               end
               default: begin
                  O_RDATA <= '0;
                  O_RRESP <= RESP_SLVERR;
               end
            endcase
         end else if (O_RVALID && I_RREADY) begin
            O_RVALID <= 1'b0;
         end
      end
   end

endmodule

// ---- verification/drs_sva.sv ----
// Checker of the sequencer pin behaviour, bound to the top module
module drs_sva
   import drs_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_ARST_N,
   input wire logic I_CE,
   input wire logic I_ENABLE_N,
   input wire logic I_ORDER_SELECT,
   input wire logic I_MANUAL_RESET_A_N,
   input wire logic I_MANUAL_RESET_B_N,
   input wire logic I_FIRST_RAIL_83,
   input wire logic I_FIRST_RAIL_95,
   input wire logic I_SECOND_RAIL_83,
   input wire logic I_SECOND_RAIL_95,
   input wire logic O_FIRST_RAIL_ON,
   input wire logic O_SECOND_RAIL_ON,
   input wire logic O_FIRST_RAIL_GOOD_OE,
   input wire logic O_SUPERVISOR_RESET_N_OE,
   input wire logic O_IRQ
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [CNT_W-1:0] run;
   // ----
   // Release delay reference
   // ----
   // Counts edges with every pin hold cause clear; saturates so it never wraps
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         run <= '0;
      end else if (I_CE) begin
         if (I_ENABLE_N || !I_SECOND_RAIL_95 || !I_MANUAL_RESET_A_N || !I_MANUAL_RESET_B_N) begin
            run <= '0;
         end else if (run != '1) begin
            run <= run + 1'b1;
         end
      end
   end
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_ARST_N);
   property p_off; I_CE && I_ENABLE_N |=> !O_FIRST_RAIL_ON && !O_SECOND_RAIL_ON; endproperty
   a_off: assert property (p_off) else $error("rail on in shutdown");
   property p_sec_first; $rose(O_FIRST_RAIL_ON) && I_ORDER_SELECT |-> $past(I_SECOND_RAIL_83); endproperty
   a_sec_first: assert property (p_sec_first) else $error("first rail early");
   property p_drop; I_CE && I_ORDER_SELECT && !I_SECOND_RAIL_83 |=> !O_FIRST_RAIL_ON; endproperty
   a_drop: assert property (p_drop) else $error("first rail kept on");
   property p_fst_first; $rose(O_SECOND_RAIL_ON) && !I_ORDER_SELECT |-> $past(I_FIRST_RAIL_83); endproperty
   a_fst_first: assert property (p_fst_first) else $error("second rail early");
   property p_good; I_CE && !I_ENABLE_N && I_FIRST_RAIL_95 && O_FIRST_RAIL_ON
      |=> !O_FIRST_RAIL_GOOD_OE; endproperty
   a_good: assert property (p_good) else $error("good not released");
   property p_bad; I_CE && !I_FIRST_RAIL_95 |=> O_FIRST_RAIL_GOOD_OE; endproperty
   a_bad: assert property (p_bad) else $error("good not pulled low");
   property p_mr; I_CE && !(I_MANUAL_RESET_A_N && I_MANUAL_RESET_B_N) |=> O_SUPERVISOR_RESET_N_OE;
   endproperty
   a_mr: assert property (p_mr) else $error("manual reset ignored");
   property p_rel; $fell(O_SUPERVISOR_RESET_N_OE) |-> run >= CNT_W'(RST_DELAY_CYC); endproperty
   a_rel: assert property (p_rel) else $error("reset released early");
   property p_loss; I_CE && !I_SECOND_RAIL_95 |=> O_SUPERVISOR_RESET_N_OE; endproperty
   a_loss: assert property (p_loss) else $error("reset kept released");
   property p_sd; I_CE && I_ENABLE_N |=> O_SUPERVISOR_RESET_N_OE && O_FIRST_RAIL_GOOD_OE; endproperty
   a_sd: assert property (p_sd) else $error("shutdown outputs wrong");
   c_up: cover property ($rose(O_FIRST_RAIL_ON));
   c_good: cover property ($fell(O_FIRST_RAIL_GOOD_OE));
   c_irq: cover property ($rose(O_IRQ));
endmodule

bind drs_sequencer drs_sva u_sva (.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_CE(I_CE),
   .I_ENABLE_N(I_ENABLE_N), .I_ORDER_SELECT(I_ORDER_SELECT),
   .I_MANUAL_RESET_A_N(I_MANUAL_RESET_A_N), .I_MANUAL_RESET_B_N(I_MANUAL_RESET_B_N),
   .I_FIRST_RAIL_83(I_FIRST_RAIL_83), .I_FIRST_RAIL_95(I_FIRST_RAIL_95),
   .I_SECOND_RAIL_83(I_SECOND_RAIL_83), .I_SECOND_RAIL_95(I_SECOND_RAIL_95),
   .O_FIRST_RAIL_ON(O_FIRST_RAIL_ON), .O_SECOND_RAIL_ON(O_SECOND_RAIL_ON),
   .O_FIRST_RAIL_GOOD_OE(O_FIRST_RAIL_GOOD_OE),
   .O_SUPERVISOR_RESET_N_OE(O_SUPERVISOR_RESET_N_OE), .O_IRQ(O_IRQ));

// ---- verification/drs_proc_model.sv ----
// Processor side model: pull-ups on the open-drain lines, manual reset drivers
module drs_proc_model (
   input  wire logic i_good_oe,
   input  wire logic i_reset_oe,
   input  wire logic i_mr_a_en,
   input  wire logic i_mr_b_en,
   input  wire logic i_tie_b,
   output logic      o_good,
   output logic      o_reset_n,
   output logic      o_mr_a_n,
   output logic      o_mr_b_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Open-drain lines idle high through board pull-ups
   assign o_good    = !i_good_oe;
   assign o_reset_n = !i_reset_oe;
   // Undriven manual reset lines read inactive
   assign o_mr_a_n  = !i_mr_a_en;
   // Optional strap of the good line onto the second manual reset
   assign o_mr_b_n  = !i_mr_b_en && (!i_tie_b || o_good);
endmodule

// ---- verification/drs_tb.sv ----
// Self-checking bench for the dual rail sequencer supervisor
module testbench
   import drs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, arst_n, en_n, sel, f83, f95, s83, s95, mra_en, mrb_en, tie_b;
   logic r1, r2, goe, roe, irq, mra_n, mrb_n, irq_a;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   // Rows: {en_n, sel, f83, f95, s83, s95, rail1, rail2, good_oe, reset_oe}
   logic [9:0] rows [10] = '{10'h303, 10'h107, 10'h12F, 10'h1FD, 10'h107,
                             10'h303, 10'h00B, 10'h08F, 10'h0FD, 10'h03F};

   drs_sequencer dut_u (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_CE(1'b1), .I_ENABLE_N(en_n),
      .I_ORDER_SELECT(sel), .I_MANUAL_RESET_A_N(mra_n), .I_MANUAL_RESET_B_N(mrb_n),
      .I_FIRST_RAIL_83(f83), .I_FIRST_RAIL_95(f95), .I_SECOND_RAIL_83(s83),
      .I_SECOND_RAIL_95(s95), .O_FIRST_RAIL_ON(r1), .O_SECOND_RAIL_ON(r2),
      .O_FIRST_RAIL_GOOD_OE(goe), .O_SUPERVISOR_RESET_N_OE(roe), .O_IRQ(irq),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
      .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
      .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
      .I_RREADY(rready));
   drs_proc_model proc_u (.i_good_oe(goe), .i_reset_oe(roe), .i_mr_a_en(mra_en),
      .i_mr_b_en(mrb_en), .i_tie_b(tie_b), .o_good(), .o_reset_n(), .o_mr_a_n(mra_n),
      .o_mr_b_n(mrb_n));

   // ----
   // Clock, watchdog and helpers
   // ----
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // The whole run needs little more than a hundred cycles; far beyond that means a hang
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end
   task automatic results();
      if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Write master: both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // ----
   // Main sequence
   // ----
   initial begin
      {arst_n, en_n, sel, f83, f95, s83, s95, mra_en, mrb_en, tie_b} = 10'h0C0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      wstrb <= 4'hF;
      rd(ADDR_IRQ_MASK, d, r);
      chk("mask reset", {28'h0, IRQ_MASK_RST}, d);
      rd(ADDR_CTRL, d, r);
      chk("ctrl reset", {31'h0, SW_HOLD_RST}, d);
      // Sequence table; state carries from row to row
      foreach (rows[i]) begin
         @(posedge clk);
         {en_n, sel, f83, f95, s83, s95} <= rows[i][9:4];
         repeat (3) @(posedge clk);
         #1;
         chk("pins", {28'h0, rows[i][3:0]}, {28'h0, r1, r2, goe, roe});
      end
      rd(ADDR_STATUS, d, r);
      chk("status", 32'hE7, d);
      rd(ADDR_IRQ_STAT, d, r);
      chk("irq events", 32'hC, d);
      // Mask polarity is left open, so only a change of the line is demanded
      wr(ADDR_IRQ_MASK, 32'h0, r);
      repeat (2) @(posedge clk);
      #1 irq_a = irq;
      wr(ADDR_IRQ_MASK, 32'hF, r);
      repeat (2) @(posedge clk);
      #1 chk("irq mask", {31'h0, !irq_a}, {31'h0, irq});
      wr(ADDR_IRQ_STAT, 32'hF, r);
      rd(ADDR_IRQ_STAT, d, r);
      chk("irq clear", 32'h0, d);
      rd(8'h10, d, r);
      chk("unmapped rd", {30'h0, RESP_SLVERR}, {d[29:0], r});
      wr(8'h10, 32'h1, r);
      chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, r});
      // Manual reset lines, then good strapped onto the second one
      mra_en <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("mr a", 32'h1, {31'h0, roe});
      rd(ADDR_STATUS, d, r);
      chk("mr a seen", 32'h0, {31'h0, d[1]});
      mra_en <= 1'b0;
      tie_b <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("mr b strap", 32'h1, {30'h0, mrb_n, roe});
      // Reset in mid-run forces every output to its safe level
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("mid reset", 32'h6, {27'h0, r1, r2, goe, roe, irq});
      // Second release: sequence restarts and the second rail waits again
      @(posedge clk);
      arst_n <= 1'b1;
      tie_b <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("restart", 32'hB, {28'h0, r1, r2, goe, roe});
      rd(ADDR_IRQ_MASK, d, r);
      chk("mask cleared", {28'h0, IRQ_MASK_RST}, d);
      results();
   end
endmodule
